// [core/config_cycle_address_router.sv]
// Configuration address port and configuration cycle router on the host I/O port.
// Assumes host I/O requests and bridge bus numbers come from logic on clk_i.
//
// Overview of operation
// (RULE1) Registers take byte, word, dword; address port dword
// (RULE2) Multi-byte fields are little-endian by lane
// (RULE3) Address port at 0CF8h, reset zero, dword only
// (RULE4) Byte or word at 0CF8h passes to expansion bus
// (RULE5) Bit 31 enables configuration cycles
// (RULE6) Bits 30:24 read zero, ignore writes
// (RULE7) Bus 0: internal device or hub type 0
// (RULE8) Bus equals secondary: graphics type 0
// (RULE9) Bus above secondary up to subordinate: graphics type 1
// (RULE10) Bus outside bridge range: hub type 1
// (RULE11) Device field copied for type 1, decoded type 0
// (RULE12) Own devices are 0, 1 and 2
// (RULE13) Graphics type 0: one select line, 16..31
// (RULE14) Device above 15: no select, master abort
// (RULE15) Device field on address bits 15:11
// (RULE16) Function copied; own devices answer function 0
// (RULE17) Register field on address bits 7:2
// (RULE18) Only address port then data window method
// (RULE19) Gate set: data window access becomes config
// (RULE20) Bus 0 devices 3..31 go to hub
// (RULE21) Bits 1:0 reserved, read zero, not decoded
`timescale 1ns/10ps

module config_cycle_address_router (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic io_req_i,
   input wire logic io_write_i,
   input wire logic [15:0] io_addr_i,
   input wire logic [3:0] io_be_i,
   input wire logic [31:0] io_wdata_i,
   input wire logic [7:0] sec_bus_i,
   input wire logic [7:0] sub_bus_i,
   output logic io_ack_o,
   output logic [31:0] io_rdata_o,
   output logic cfg_req_o,
   output logic cfg_write_o,
   output cfg_route_pkg::cfg_target_t cfg_target_o,
   output logic [31:0] cfg_addr_o,
   output logic [3:0] cfg_be_o,
   output logic [31:0] cfg_wdata_o,
   output logic [2:0] int_dev_sel_o,
   output logic int_master_abort_o,
   output logic gp_master_abort_o,
   output logic pass_req_o,
   output logic pass_write_o,
   output logic [15:0] pass_addr_o,
   output logic [3:0] pass_be_o,
   output logic [31:0] pass_wdata_o
);
   import cfg_route_pkg::*;

   typedef struct packed {
      logic [31:0] addr_port;
      logic ack;
      logic [31:0] rdata;
      logic cfg_req;
      logic cfg_write;
      cfg_target_t cfg_target;
      logic [31:0] cfg_addr;
      logic [3:0] cfg_be;
      logic [31:0] cfg_wdata;
      logic [2:0] int_sel;
      logic int_abort;
      logic gp_abort;
      logic pass_req;
      logic pass_write;
      logic [15:0] pass_addr;
      logic [3:0] pass_be;
      logic [31:0] pass_wdata;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // Field views of the stored address port

   logic gate;
   logic [7:0] bus;
   logic [4:0] dev;
   logic [2:0] fn;
   logic [5:0] regn;
   logic [15:0] gp_sel;

   assign gate = state_r.addr_port[GATE_BIT];
   assign bus = state_r.addr_port[BUS_LSB +: 8];
   assign dev = state_r.addr_port[DEV_LSB +: 5];
   assign fn = state_r.addr_port[FN_LSB +: 3];
   assign regn = state_r.addr_port[REG_LSB +: 6];

   // One select line per graphics port device; devices above 15 match none
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_sel
         assign gp_sel[gi] = (dev == 5'(gi)); // [RULE13] [RULE14]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Host access decode

   logic hit_addr_word;
   logic hit_addr_port;
   logic hit_window;
   logic own_dev;

   assign hit_addr_word = (io_addr_i[15:2] == CONFIG_ADDRESS_PORT_OFS[15:2]);
   assign hit_addr_port = hit_addr_word && (io_be_i == BE_DWORD); // [RULE1] [RULE3]
   // Only the dword address port plus data window method is decoded [RULE18]
   assign hit_window = (io_addr_i[15:2] == CONFIG_DATA_WINDOW_OFS[15:2]);
   assign own_dev = (dev == DEV_HOST_BRIDGE) || (dev == DEV_GFX_BRIDGE) || (dev == DEV_INT_GFX); // [RULE12]

   always_comb begin
      state_nxt = state_r;
      state_nxt.ack = 1'b0;
      state_nxt.cfg_req = 1'b0;
      state_nxt.int_abort = 1'b0;
      state_nxt.gp_abort = 1'b0;
      state_nxt.pass_req = 1'b0;
      if (io_req_i) begin
         state_nxt.ack = 1'b1;
         state_nxt.rdata = 32'h0000_0000;
         if (hit_addr_port) begin
            if (io_write_i) begin
               // Reserved bits are dropped so they read back zero [RULE6] [RULE21]
               state_nxt.addr_port = io_wdata_i & CONFIG_ADDRESS_WR_MASK; // [RULE3]
            end else begin
               state_nxt.rdata = state_r.addr_port; // [RULE2]
            end
         end else if (hit_window && gate) begin
            // Byte lanes pass unchanged, lane 0 is the lowest address [RULE2] [RULE19]
            state_nxt.cfg_req = 1'b1; // [RULE5]
            state_nxt.cfg_write = io_write_i;
            state_nxt.cfg_be = io_be_i; // [RULE1]
            state_nxt.cfg_wdata = io_wdata_i;
            state_nxt.int_sel = 3'h0;
            state_nxt.cfg_addr = {8'h00, bus, dev, fn, regn, CYC_TYPE1}; // [RULE15] [RULE16] [RULE17]
            if (bus == BUS_ZERO) begin
               if (own_dev) begin
                  // Kept inside, never sent to the hub [RULE7] [RULE20]
                  state_nxt.cfg_target = TGT_INTERNAL;
                  state_nxt.cfg_addr = {16'h0000, dev, fn, regn, CYC_TYPE0};
                  if (fn == FN_ZERO) begin
                     state_nxt.int_sel = 3'(1 << dev[1:0]); // [RULE12]
                  end else begin
                     state_nxt.int_abort = 1'b1; // [RULE16]
                  end
               end else begin
                  state_nxt.cfg_target = TGT_HUB_T0; // [RULE7] [RULE20]
                  state_nxt.cfg_addr = {16'h0000, dev, fn, regn, CYC_TYPE0}; // [RULE15]
               end
            end else if (bus == sec_bus_i) begin
               state_nxt.cfg_target = TGT_GP_T0; // [RULE8]
               state_nxt.cfg_addr = {gp_sel, 5'h00, fn, regn, CYC_TYPE0}; // [RULE11] [RULE13]
               state_nxt.gp_abort = (dev > GP_DEV_MAX); // [RULE14]
            end else if ((bus > sec_bus_i) && (bus <= sub_bus_i)) begin
               state_nxt.cfg_target = TGT_GP_T1; // [RULE9] [RULE11]
            end else begin
               state_nxt.cfg_target = TGT_HUB_T1; // [RULE10] [RULE11]
            end
         end else begin
            // Partial address port access, disabled window, or other I/O [RULE4]
            state_nxt.pass_req = 1'b1;
            state_nxt.pass_write = io_write_i;
            state_nxt.pass_addr = io_addr_i;
            state_nxt.pass_be = io_be_i;
            state_nxt.pass_wdata = io_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_r <= '0;
         state_r.addr_port <= CONFIG_ADDRESS_PORT_RST; // [RULE3]
         state_r.cfg_target <= TGT_NONE;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   assign io_ack_o = state_r.ack;
   assign io_rdata_o = state_r.rdata;
   assign cfg_req_o = state_r.cfg_req;
   assign cfg_write_o = state_r.cfg_write;
   assign cfg_target_o = state_r.cfg_target;
   assign cfg_addr_o = state_r.cfg_addr;
   assign cfg_be_o = state_r.cfg_be;
   assign cfg_wdata_o = state_r.cfg_wdata;
   assign int_dev_sel_o = state_r.int_sel;
   assign int_master_abort_o = state_r.int_abort;
   assign gp_master_abort_o = state_r.gp_abort;
   assign pass_req_o = state_r.pass_req;
   assign pass_write_o = state_r.pass_write;
   assign pass_addr_o = state_r.pass_addr;
   assign pass_be_o = state_r.pass_be;
   assign pass_wdata_o = state_r.pass_wdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   AST_ADDR_WRITE: assert property ( // [RULE3]
      io_req_i && io_write_i && hit_addr_port
      |=> state_r.addr_port == ($past(io_wdata_i) & CONFIG_ADDRESS_WR_MASK))
      else $error("address port write not stored");

   AST_PARTIAL_PASS: assert property ( // [RULE4]
      io_req_i && hit_addr_word && io_be_i != BE_DWORD
      |=> pass_req_o && $stable(state_r.addr_port) && !cfg_req_o)
      else $error("partial address port access not passed through");

   AST_RESERVED_ZERO: assert property ( // [RULE6]
      io_req_i && !io_write_i && hit_addr_port
      |=> io_ack_o && io_rdata_o[30:24] == 7'h00 && io_rdata_o[1:0] == 2'h0)
      else $error("reserved address port bits read nonzero");

   AST_GATE: assert property ( // [RULE5]
      io_req_i && hit_window
      |=> (cfg_req_o == $past(gate)) && (pass_req_o == !$past(gate)))
      else $error("data window routing ignores the gate");

   AST_BUS0_INTERNAL: assert property ( // [RULE20]
      cfg_req_o && cfg_target_o == TGT_INTERNAL |-> bus == BUS_ZERO && dev <= DEV_INT_GFX)
      else $error("internal target outside own devices");

   AST_GP_ONEHOT: assert property ( // [RULE13]
      cfg_req_o && cfg_target_o == TGT_GP_T0 && !gp_master_abort_o
      |-> $onehot(cfg_addr_o[31:GP_SEL_LSB]) && cfg_addr_o[GP_SEL_LSB + dev[3:0]])
      else $error("graphics select line wrong");

   AST_GP_ABORT: assert property ( // [RULE14]
      cfg_req_o && cfg_target_o == TGT_GP_T0 && dev > GP_DEV_MAX
      |-> gp_master_abort_o && cfg_addr_o[31:GP_SEL_LSB] == 16'h0000)
      else $error("high device did not abort");

   AST_TYPE1_FIELDS: assert property ( // [RULE11]
      cfg_req_o && (cfg_target_o == TGT_GP_T1 || cfg_target_o == TGT_HUB_T1)
      |-> cfg_addr_o[15:0] == {dev, fn, regn, CYC_TYPE1} && cfg_addr_o[23:16] == bus)
      else $error("type 1 address fields wrong");

   AST_FN_ABORT: assert property ( // [RULE16]
      cfg_req_o && cfg_target_o == TGT_INTERNAL
      |-> (int_master_abort_o == (fn != FN_ZERO)) && (int_dev_sel_o == 3'h0) == (fn != FN_ZERO))
      else $error("function abort wrong for own device");

   AST_RANGE_GP1: assert property ( // [RULE9]
      io_req_i && hit_window && gate && bus != BUS_ZERO && bus > sec_bus_i && bus <= sub_bus_i
      |=> cfg_target_o == TGT_GP_T1)
      else $error("bridge range not routed to graphics type 1");

   AST_RANGE_HUB1: assert property ( // [RULE10]
      io_req_i && hit_window && gate && bus != BUS_ZERO && (bus < sec_bus_i || bus > sub_bus_i)
      |=> cfg_target_o == TGT_HUB_T1)
      else $error("out of range bus not routed to hub type 1");

   AST_SEC_GP0: assert property ( // [RULE8]
      io_req_i && hit_window && gate && bus != BUS_ZERO && bus == sec_bus_i
      |=> cfg_target_o == TGT_GP_T0)
      else $error("secondary bus not routed to graphics type 0");

   AST_ACK_EVERY: assert property ( // [RULE1]
      io_req_i |=> io_ack_o)
      else $error("host request not acknowledged");

   AST_ACK_ONLY: assert property ( // [RULE1]
      !io_req_i |=> !io_ack_o && !cfg_req_o && !pass_req_o)
      else $error("answer without a request");

   AST_ONE_ANSWER: assert property ( // [RULE19]
      io_ack_o |-> !(cfg_req_o && pass_req_o))
      else $error("request both forwarded and turned into a configuration cycle");

   AST_WINDOW_CFG: assert property ( // [RULE19]
      io_req_i && hit_window && gate
      |=> cfg_req_o && !pass_req_o && cfg_write_o == $past(io_write_i))
      else $error("data window access not converted");

   AST_LANES_KEPT: assert property ( // [RULE2]
      io_req_i && hit_window && gate
      |=> cfg_be_o == $past(io_be_i) && cfg_wdata_o == $past(io_wdata_i))
      else $error("byte lanes of window access changed");

   AST_BUS0_HUB: assert property ( // [RULE7] [RULE20]
      io_req_i && hit_window && gate && bus == BUS_ZERO && !own_dev
      |=> cfg_target_o == TGT_HUB_T0)
      else $error("bus 0 foreign device not sent to hub type 0");

   AST_BUS0_OWN: assert property ( // [RULE7]
      io_req_i && hit_window && gate && bus == BUS_ZERO && own_dev
      |=> cfg_target_o == TGT_INTERNAL)
      else $error("own device access left the block");

   AST_INT_SEL: assert property ( // [RULE12]
      cfg_req_o && cfg_target_o == TGT_INTERNAL && fn == FN_ZERO
      |-> $onehot(int_dev_sel_o) && int_dev_sel_o[dev[1:0]])
      else $error("internal device select wrong");

   AST_HUB_DEV_FIELD: assert property ( // [RULE15]
      cfg_req_o && cfg_target_o == TGT_HUB_T0
      |-> cfg_addr_o[15:11] == dev && cfg_addr_o[31:16] == 16'h0000 && cfg_addr_o[1:0] == CYC_TYPE0)
      else $error("hub type 0 address fields wrong");

   AST_FN_REG_FIELDS: assert property ( // [RULE16] [RULE17]
      cfg_req_o |-> cfg_addr_o[10:8] == fn && cfg_addr_o[7:2] == regn)
      else $error("function or register field not carried");

   AST_PORT_RESERVED: assert property ( // [RULE21] [RULE6]
      state_r.addr_port[1:0] == 2'h0 && state_r.addr_port[30:24] == 7'h00)
      else $error("reserved address port bits stored");

   AST_PARTIAL_COPY: assert property ( // [RULE4]
      io_req_i && hit_addr_word && io_be_i != BE_DWORD
      |=> pass_addr_o == $past(io_addr_i) && pass_be_o == $past(io_be_i)
          && pass_wdata_o == $past(io_wdata_i) && pass_write_o == $past(io_write_i))
      else $error("forwarded cycle differs from request");

   AST_PORT_NOT_FORWARDED: assert property ( // [RULE3]
      io_req_i && hit_addr_port |=> !pass_req_o && !cfg_req_o)
      else $error("dword address port access forwarded");

   AST_GP_ABORT_SCOPE: assert property ( // [RULE14]
      gp_master_abort_o |-> cfg_req_o && cfg_target_o == TGT_GP_T0)
      else $error("graphics abort outside graphics type 0");

   COV_INTERNAL: cover property (cfg_req_o && cfg_target_o == TGT_INTERNAL && int_dev_sel_o != 3'h0);
   COV_GP_T0: cover property (cfg_req_o && cfg_target_o == TGT_GP_T0);
   COV_HUB_T1: cover property (cfg_req_o && cfg_target_o == TGT_HUB_T1);
   COV_PASS: cover property (io_req_i && hit_addr_word && io_be_i != BE_DWORD ##1 pass_req_o);
   COV_HUB_T0: cover property (cfg_req_o && cfg_target_o == TGT_HUB_T0);

endmodule : config_cycle_address_router

// [core/cfg_route_pkg.sv]
// Constants, field layouts and target codes for the configuration cycle router.
// Assumes one host clock domain shared with the host I/O port and downstream logic.
package cfg_route_pkg;

   // Host I/O map, as byte addresses
   localparam logic [15:0] CONFIG_ADDRESS_PORT_OFS = 16'h0cf8;
   localparam logic [15:0] CONFIG_DATA_WINDOW_OFS = 16'h0cfc;
   localparam logic [31:0] CONFIG_ADDRESS_PORT_RST = 32'h0000_0000;
   localparam logic [3:0] BE_DWORD = 4'hf;

   // Writable bits of the address port: gate, bus, device, function, register
   localparam logic [31:0] CONFIG_ADDRESS_WR_MASK = 32'h80ff_fffc;

   // Field positions in the address port
   localparam int GATE_BIT = 31;
   localparam int BUS_LSB = 16;
   localparam int DEV_LSB = 11;
   localparam int FN_LSB = 8;
   localparam int REG_LSB = 2;

   // Internal device numbers on bus 0
   localparam logic [4:0] DEV_HOST_BRIDGE = 5'h00;
   localparam logic [4:0] DEV_GFX_BRIDGE = 5'h01;
   localparam logic [4:0] DEV_INT_GFX = 5'h02;
   localparam logic [2:0] FN_ZERO = 3'h0;
   localparam logic [7:0] BUS_ZERO = 8'h00;

   // Graphics port select lines: device 0 on line 16, last device 15
   localparam int GP_SEL_LSB = 16;
   localparam logic [4:0] GP_DEV_MAX = 5'h0f;

   // Low address bits of generated cycles
   localparam logic [1:0] CYC_TYPE0 = 2'h0;
   localparam logic [1:0] CYC_TYPE1 = 2'h1;

   typedef enum logic [2:0] {
      TGT_NONE,
      TGT_INTERNAL,
      TGT_HUB_T0,
      TGT_HUB_T1,
      TGT_GP_T0,
      TGT_GP_T1
   } cfg_target_t;

endpackage : cfg_route_pkg

// [bench/downstream_model.sv]
// Stand-in for the hub and graphics port ends of generated configuration cycles.
// Assumes cycles arrive as one-cycle pulses on clk_i.
`timescale 1ns/10ps
module downstream_model (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic cfg_req_i,
   input cfg_route_pkg::cfg_target_t cfg_target_i,
   input wire logic [31:0] cfg_addr_i,
   output logic [31:0] seen_addr_o,
   output logic [7:0] seen_cnt_o,
   output logic bad_o
);
   import cfg_route_pkg::*;
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         seen_addr_o <= 32'h0000_0000;
         seen_cnt_o <= 8'h00;
         bad_o <= 1'b0;
      end else if (cfg_req_i) begin
         seen_addr_o <= cfg_addr_i;
         seen_cnt_o <= seen_cnt_o + 8'h01;
         // Low bits tell type 1 from type 0; a mix-up misroutes behind bridges
         if ((cfg_target_i == TGT_HUB_T1 || cfg_target_i == TGT_GP_T1) != (cfg_addr_i[1:0] == CYC_TYPE1)) begin
            bad_o <= 1'b1;
         end
         if (cfg_target_i == TGT_GP_T0 && !$onehot0(cfg_addr_i[31:16])) begin
            bad_o <= 1'b1;
         end
      end
   end
endmodule : downstream_model

// [bench/config_cycle_address_router_tb.sv]
// Self-checking bench for the configuration cycle router.
// Assumes the downstream model stands in for hub and graphics port.
`timescale 1ns/10ps
module config_cycle_address_router_tb;
   import cfg_route_pkg::*;
   logic clk, resetn, req, wr, ack, cfg_req, cfg_wr, ima, gma, p_req, p_wr, bad;
   logic [15:0] addr, p_addr;
   logic [3:0] be, c_be, p_be;
   logic [31:0] wd, rdata, c_addr, c_wd, p_wd, seen_addr;
   logic [7:0] sec, sub, seen_cnt;
   logic [2:0] sel;
   cfg_target_t tgt;
   int errors, checked;
   config_cycle_address_router config_cycle_address_router_i (.clk_i(clk), .resetn_i(resetn),
      .io_req_i(req), .io_write_i(wr), .io_addr_i(addr), .io_be_i(be), .io_wdata_i(wd),
      .sec_bus_i(sec), .sub_bus_i(sub), .io_ack_o(ack), .io_rdata_o(rdata), .cfg_req_o(cfg_req),
      .cfg_write_o(cfg_wr), .cfg_target_o(tgt), .cfg_addr_o(c_addr), .cfg_be_o(c_be),
      .cfg_wdata_o(c_wd), .int_dev_sel_o(sel), .int_master_abort_o(ima), .gp_master_abort_o(gma),
      .pass_req_o(p_req), .pass_write_o(p_wr), .pass_addr_o(p_addr), .pass_be_o(p_be),
      .pass_wdata_o(p_wd));
   downstream_model downstream_model_i (.clk_i(clk), .resetn_i(resetn), .cfg_req_i(cfg_req),
      .cfg_target_i(tgt), .cfg_addr_i(c_addr), .seen_addr_o(seen_addr), .seen_cnt_o(seen_cnt),
      .bad_o(bad));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk
   task done(input string n);
      $display("test %s done, errors %0d", n, errors);
   endtask : done
   // One request, answer sampled one edge later
   task io(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
      @(posedge clk) #1;
      req = 1'b1;
      wr = w;
      addr = a;
      be = b;
      wd = d;
      @(posedge clk) #1;
      req = 1'b0;
      chk(32'h1, {31'h0, ack});
   endtask : io
   ////////////////////////////////////////////////////////////////////////////////
   task t_reset;
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(32'h0, rdata);
      chk(32'h0, {31'h0, p_req});
      done("reset");
   endtask : t_reset
   task t_addr_reg;
      io(1'b1, 16'h0cf8, 4'hf, 32'hffff_ffff);
      chk(32'h0, {31'h0, p_req});
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(32'h80ff_fffc, rdata);
      done("addr_reg");
   endtask : t_addr_reg
   task t_partial;
      io(1'b1, 16'h0cf8, 4'h3, 32'h0000_1234);
      chk(32'h1, {31'h0, p_req});
      chk({16'h0, 16'h0cf8}, {16'h0, p_addr});
      chk(32'h3, {28'h0, p_be});
      chk(32'h0000_1234, p_wd);
      chk(32'h1, {31'h0, p_wr});
      io(1'b0, 16'h0cf8, 4'hf, 32'h0);
      chk(32'h80ff_fffc, rdata);
      done("partial");
   endtask : t_partial
   task t_gate_off;
      io(1'b1, 16'h0cf8, 4'hf, 32'h0000_0800);
      io(1'b0, 16'h0cfc, 4'hf, 32'h0);
      chk(32'h1, {31'h0, p_req});
      chk(32'h0, {31'h0, cfg_req});
      done("gate_off");
   endtask : t_gate_off
   // Address port first, then a window write; reserved low bits set on purpose
   task route(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f, input logic [5:0] r,
              input cfg_target_t t, input logic [31:0] a, input logic [2:0] s, input logic m0,
              input logic m1);
      logic [7:0] n;
      io(1'b1, 16'h0cf8, 4'hf, {1'b1, 7'h7f, b, d, f, r, 2'b11});
      n = seen_cnt;
      io(1'b1, 16'h0cfc, 4'h3, 32'hcafe_0001);
      chk(32'h1, {31'h0, cfg_req});
      chk({29'h0, t}, {29'h0, tgt});
      chk(a, c_addr);
      chk({29'h0, s}, {29'h0, sel});
      chk({30'h0, m0, m1}, {30'h0, ima, gma});
      chk(32'h13, {27'h0, cfg_wr, c_be});
      chk(32'hcafe_0001, c_wd);
      @(posedge clk) #1;
      chk({24'h0, n + 8'h01}, {24'h0, seen_cnt});
      chk(a, seen_addr);
   endtask : route
   task t_route;
      route(8'h00, 5'h00, 3'h0, 6'h01, TGT_INTERNAL, {16'h0, 5'h00, 3'h0, 6'h01, 2'b00}, 3'b001, 0, 0);
      route(8'h00, 5'h01, 3'h0, 6'h03, TGT_INTERNAL, {16'h0, 5'h01, 3'h0, 6'h03, 2'b00}, 3'b010, 0, 0);
      route(8'h00, 5'h02, 3'h1, 6'h00, TGT_INTERNAL, {16'h0, 5'h02, 3'h1, 6'h00, 2'b00}, 3'b000, 1, 0);
      route(8'h00, 5'h03, 3'h4, 6'h02, TGT_HUB_T0, {16'h0, 5'h03, 3'h4, 6'h02, 2'b00}, 3'b000, 0, 0);
      route(8'h04, 5'h02, 3'h5, 6'h3f, TGT_GP_T0, {16'h0004, 5'h0, 3'h5, 6'h3f, 2'b00}, 3'b000, 0, 0);
      route(8'h04, 5'h0f, 3'h0, 6'h00, TGT_GP_T0, {16'h8000, 5'h0, 3'h0, 6'h00, 2'b00}, 3'b000, 0, 0);
      route(8'h04, 5'h10, 3'h0, 6'h01, TGT_GP_T0, {16'h0000, 5'h0, 3'h0, 6'h01, 2'b00}, 3'b000, 0, 1);
      route(8'h08, 5'h07, 3'h2, 6'h10, TGT_GP_T1, {8'h0, 8'h08, 5'h07, 3'h2, 6'h10, 2'b01}, 3'b000, 0, 0);
      route(8'h09, 5'h1f, 3'h7, 6'h00, TGT_HUB_T1, {8'h0, 8'h09, 5'h1f, 3'h7, 6'h00, 2'b01}, 3'b000, 0, 0);
      route(8'h02, 5'h00, 3'h0, 6'h01, TGT_HUB_T1, {8'h0, 8'h02, 5'h00, 3'h0, 6'h01, 2'b01}, 3'b000, 0, 0);
      done("route");
   endtask : t_route
   task end_sim;
      chk(32'h0, {31'h0, bad});
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Whole run needs under a hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      end_sim();
   end
   initial begin
      {resetn, req, wr, addr, be, wd} = '0;
      sec = 8'h04;
      sub = 8'h08;
      repeat (16) @(posedge clk);
      #1 resetn = 1'b1;
      t_reset();
      t_addr_reg();
      t_partial();
      t_gate_off();
      t_route();
      end_sim();
   end
endmodule : config_cycle_address_router_tb
